// file: rtl/swire_pkg.sv
package swire_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_NS             = 50;
   localparam int RESET_LOW_TIME_US  = 480;
   localparam int RESET_LOW_FAST_US  = 48;
   localparam int FAST_KEEP_US       = 80;
   localparam int RESET_HIGH_TIME_US = 480;
   localparam int RESET_HIGH_FAST_US = 48;
   localparam int RESET_LOW_LIMIT_US = 960;
   localparam int PRESENCE_WAIT_US   = 30;
   localparam int PRESENCE_WAIT_F_US = 3;
   localparam int PRESENCE_LOW_US    = 120;
   localparam int PRESENCE_LOW_F_US  = 12;
   localparam int LOW1_MAX_US        = 15;
   localparam int LOW0_MIN_US        = 60;
   localparam int LOW1_MAX_F_US      = 2;
   localparam int LOW0_MIN_F_US      = 6;
   localparam int READ_VALID_US      = 15;
   localparam int READ_VALID_F_US    = 2;
   localparam int SLOT_US            = 70;
   localparam int SLOT_F_US          = 8;
   localparam int SLOT_RECOVERY_US   = 1;
   localparam int SLOT_RECOVERY_F_US = 1;
   localparam int DRIVE_US           = 1;

   // Cycle counts: least times round up, longest times round down.
   function automatic int cyc_up(input int us);
      return (us * 1000 + CLK_NS - 1) / CLK_NS;
   endfunction : cyc_up

   localparam int RST_LOW_CYC     = cyc_up(RESET_LOW_TIME_US);
   localparam int RST_LOW_F_CYC   = cyc_up(RESET_LOW_FAST_US);
   localparam int FAST_KEEP_CYC   = (FAST_KEEP_US * 1000) / CLK_NS;
   localparam int RST_HIGH_CYC    = cyc_up(RESET_HIGH_TIME_US);
   localparam int RST_HIGH_F_CYC  = cyc_up(RESET_HIGH_FAST_US);
   localparam int PRES_WAIT_CYC   = cyc_up(PRESENCE_WAIT_US);
   localparam int PRES_WAIT_F_CYC = cyc_up(PRESENCE_WAIT_F_US);
   localparam int PRES_LOW_CYC    = cyc_up(PRESENCE_LOW_US);
   localparam int PRES_LOW_F_CYC  = cyc_up(PRESENCE_LOW_F_US);
   localparam int SAMPLE_CYC      = cyc_up(30);
   localparam int SAMPLE_F_CYC    = cyc_up(4);
   localparam int LOW0_CYC        = cyc_up(LOW0_MIN_US);
   localparam int LOW0_F_CYC      = cyc_up(LOW0_MIN_F_US);
   localparam int LOW1_CYC        = cyc_up(5);
   localparam int LOW1_F_CYC      = cyc_up(DRIVE_US);
   localparam int READ_HOLD_CYC   = cyc_up(READ_VALID_US);
   localparam int READ_HOLD_F_CYC = cyc_up(READ_VALID_F_US);
   localparam int READ_SMP_CYC    = cyc_up(10);
   // Fast reads are sampled between the master's release and the device's, never on either.
   localparam int READ_SMP_F_CYC  = (LOW1_F_CYC + READ_HOLD_F_CYC) / 2;
   localparam int SLOT_CYC        = cyc_up(SLOT_US);
   localparam int SLOT_F_CYC      = cyc_up(SLOT_F_US);
   localparam int REC_CYC         = cyc_up(SLOT_RECOVERY_US);
   localparam int REC_F_CYC       = cyc_up(SLOT_RECOVERY_F_US);
   localparam int CNT_W           = 16;

   // ---------------------------------------------------------------
   // Checksums
   // ---------------------------------------------------------------
   localparam logic [7:0]  CRC8_POLY_REV  = 8'h8C;
   localparam logic [15:0] CRC16_POLY_REV = 16'hA001;
   localparam logic [15:0] CRC16_INIT     = 16'h0000;
   localparam logic [4:0]  PAD_END_OFFSET = 5'h1F;

   typedef enum logic [1:0] {
      CRC_HOLD,
      CRC_CLEAR,
      CRC_BYTE
   } crc_op_t;

   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ CRC16_POLY_REV;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crc16_byte

   function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ CRC8_POLY_REV;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crc8_byte
endpackage : swire_pkg

// file: rtl/swire_if.sv
interface swire_if;
   logic dev_in;
   logic dev_out;
   logic dev_oe_n;
   logic mst_in;
   logic mst_out;
   logic mst_oe_n;
   logic line;

   // Open drain with pull-up: any enabled low driver wins.
   assign line    = !((!dev_oe_n && !dev_out) || (!mst_oe_n && !mst_out));
   assign dev_in  = line;
   assign mst_in  = line;

   modport device (input dev_in, output dev_out, output dev_oe_n);
   modport master (input mst_in, output mst_out, output mst_oe_n);
endinterface : swire_if

// file: rtl/swire_device.sv
module swire_device
   import swire_pkg::*;
#(
   parameter logic [63:0] IDENTITY = 64'h0000_0000_0000_0001  // Arbitrary value.
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // Link
   swire_if.device         bus,
   // Command flow side
   input  wire logic       fast_speed_set,
   input  wire logic       tx_req,
   input  wire logic       tx_bit,
   input  wire crc_op_t    crc_op,
   input  wire logic [7:0] crc_data,
   input  wire logic [4:0] pad_start,
   input  wire logic [5:0] pad_count,
   output logic            fast_speed_flag,
   output logic            reset_seen,
   output logic            rx_valid,
   output logic            rx_bit,
   output logic            tx_done,
   output logic [15:0]     crc_value,
   output logic [15:0]     crc_tx_word,
   output logic            crc_tx_allowed,
   output logic [7:0]      identity_crc
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // S_LOW covers every low that the master starts, slot or reset, told apart when the
   // line rises. S_SLOT_WAIT lets a held read zero go before the next fall is looked for.
   typedef enum logic [2:0] {
      S_IDLE, S_LOW, S_PRES_WAIT, S_PRES_LOW, S_SLOT_WAIT
   } dstate_t;

   // All state is one struct, so that clk_en low freezes it in one place.

   typedef struct packed {
      dstate_t        st;
      logic [CNT_W:0] cnt;
      logic           fast;
      logic           line_q;
      logic           drive_low;
      logic           rx_valid;
      logic           rx_bit;
      logic           tx_done;
      logic           rst_seen;
      logic [15:0]    crc;
   } dev_t;

   dev_t s_reg, s_next;
   logic fall;

   // Picks the count of the current speed, sized to the cycle counter.
   function automatic logic [CNT_W:0] span(input logic fast, input int fast_cyc,
                                           input int reg_cyc);
      return (CNT_W+1)'(fast ? fast_cyc : reg_cyc);
   endfunction : span

   // ---------------------------------------------------------------
   // Line edge and outputs
   // ---------------------------------------------------------------
   // The line is taken as synchronous to clk_sys; a raw pin needs a synchroniser first.
   assign fall = s_reg.line_q && !bus.dev_in;

   // The identity checksum is fixed: it is the top byte of the identity word.
   assign identity_crc   = IDENTITY[63:56];
   assign crc_value      = s_reg.crc;
   assign crc_tx_word    = ~s_reg.crc;
   // Write checksum goes out only if the data reached the last offset.
   // Seven bits, so that a late start with a long count cannot wrap.
   logic [6:0] pad_end;
   assign pad_end        = 7'(pad_start) + 7'(pad_count);
   assign crc_tx_allowed = pad_end > 7'(PAD_END_OFFSET);

   assign bus.dev_out    = 1'b0;
   assign bus.dev_oe_n   = !s_reg.drive_low;
   assign fast_speed_flag = s_reg.fast;
   assign reset_seen     = s_reg.rst_seen;
   assign rx_valid       = s_reg.rx_valid;
   assign rx_bit         = s_reg.rx_bit;
   assign tx_done        = s_reg.tx_done;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.line_q   = bus.dev_in;
      s_next.rx_valid = 1'b0;
      s_next.tx_done  = 1'b0;
      s_next.rst_seen = 1'b0;
      if (fast_speed_set) begin
         s_next.fast = 1'b1;
      end
      // The checksum runs beside the slot logic: the command flow picks the bytes and
      // the moment of clearing, so one generator serves both commands.
      case (crc_op)
         CRC_CLEAR: s_next.crc = CRC16_INIT;
         CRC_BYTE:  s_next.crc = crc16_byte(s_reg.crc, crc_data);
         default:   s_next.crc = s_reg.crc;
      endcase
      if (s_reg.cnt != '1) begin
         s_next.cnt = s_reg.cnt + 1'b1;
      end
      case (s_reg.st)
         S_IDLE: begin
            if (fall) begin
               s_next.st  = S_LOW;
               s_next.cnt = '0;
               // A zero read is held low; a one leaves the line alone.
               s_next.drive_low = tx_req && !tx_bit;
            end
         end
         S_LOW: begin
            // A held read zero is let go after the data-valid time.
            if (tx_req && s_reg.cnt >= span(s_reg.fast, READ_HOLD_F_CYC, READ_HOLD_CYC)) begin
               s_next.drive_low = 1'b0;
               if (s_reg.drive_low) begin
                  s_next.st = S_SLOT_WAIT;
               end
            end
            if (!tx_req && s_reg.cnt == span(s_reg.fast, SAMPLE_F_CYC, SAMPLE_CYC)) begin
               s_next.rx_valid = 1'b1;
               s_next.rx_bit   = bus.dev_in;
            end
            // Only a rising line ends a reset, and the floor follows the speed, so that a
            // write zero at regular speed is never taken for a reset.
            if (bus.dev_in && !s_reg.line_q && !s_reg.drive_low
                && s_reg.cnt >= span(s_reg.fast, RST_LOW_F_CYC, RST_LOW_CYC)) begin
               if (s_reg.cnt >= (CNT_W+1)'(RST_LOW_CYC)) begin
                  s_next.fast = 1'b0;
               end
               s_next.st       = S_PRES_WAIT;
               s_next.rst_seen = 1'b1;
               s_next.cnt      = '0;
            // A write slot stays until its sample point has passed, even after a write one
            // has let the line rise; a read one ends as soon as the line is back up.
            end else if (bus.dev_in && !s_reg.drive_low && (tx_req
                         || s_reg.cnt > span(s_reg.fast, SAMPLE_F_CYC, SAMPLE_CYC))) begin
               s_next.st      = S_IDLE;
               s_next.tx_done = tx_req;
               s_next.cnt     = '0;
            end
         end
         S_SLOT_WAIT: begin
            if (bus.dev_in) begin
               s_next.st      = S_IDLE;
               s_next.tx_done = 1'b1;
            end
         end
         S_PRES_WAIT: begin
            if (s_reg.cnt == (CNT_W+1)'(s_reg.fast ? PRES_WAIT_F_CYC : PRES_WAIT_CYC)) begin
               s_next.st        = S_PRES_LOW;
               s_next.cnt       = '0;
               s_next.drive_low = 1'b1;
            end
         end
         S_PRES_LOW: begin
            if (s_reg.cnt == span(s_reg.fast, PRES_LOW_F_CYC, PRES_LOW_CYC)) begin
               // Straight back to idle: the end of presence is no read slot.
               s_next.st        = S_IDLE;
               s_next.drive_low = 1'b0;
            end
         end
         default: s_next.st = S_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // The line sample starts high so that reset never looks like a rising edge.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg        <= '0;
         s_reg.line_q <= 1'b1;
         s_reg.crc    <= CRC16_INIT;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end
endmodule : swire_device

// file: rtl/swire_master.sv
module swire_master
   import swire_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // Link
   swire_if.master         bus,
   // User side
   input  wire logic       fast,
   input  wire logic       cmd_reset,
   input  wire logic       cmd_write,
   input  wire logic       cmd_read,
   input  wire logic       wr_bit,
   output logic            busy,
   output logic            done,
   output logic            rd_bit,
   output logic            presence,
   input  wire logic       crc_clear,
   input  wire logic       crc_byte,
   input  wire logic [7:0] crc_data,
   input  wire logic [15:0] crc_rx_word,
   output logic            crc16_ok,
   output logic [7:0]      crc8
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {M_IDLE, M_RST_LOW, M_RST_HIGH, M_SLOT, M_REC} mstate_t;

   typedef struct packed {
      mstate_t        st;
      logic [CNT_W:0] cnt;
      logic           low;
      logic           is_read;
      logic           bitv;
      logic           done;
      logic           rd;
      logic           pres;
      logic [15:0]    crc16;
      logic [7:0]     crc8;
   } mst_t;

   mst_t s_reg, s_next;

   assign bus.mst_out  = 1'b0;
   assign bus.mst_oe_n = !s_reg.low;
   assign busy         = s_reg.st != M_IDLE;
   assign done         = s_reg.done;
   assign rd_bit       = s_reg.rd;
   assign presence     = s_reg.pres;
   assign crc8         = s_reg.crc8;
   // Mismatch tells the user to re-read the data.
   assign crc16_ok     = (~crc_rx_word) == s_reg.crc16;

   always_comb begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      if (s_reg.cnt != '1) begin
         s_next.cnt = s_reg.cnt + 1'b1;
      end
      if (crc_clear) begin
         s_next.crc16 = CRC16_INIT;
         s_next.crc8  = 8'h00;
      end else if (crc_byte) begin
         s_next.crc16 = crc16_byte(s_reg.crc16, crc_data);
         s_next.crc8  = crc8_byte(s_reg.crc8, crc_data);
      end
      case (s_reg.st)
         M_IDLE: begin
            s_next.cnt = '0;
            if (cmd_reset) begin
               s_next.st   = M_RST_LOW;
               s_next.low  = 1'b1;
               s_next.pres = 1'b0;
            end else if (cmd_write || cmd_read) begin
               s_next.st      = M_SLOT;
               s_next.low     = 1'b1;
               s_next.is_read = cmd_read;
               s_next.bitv    = wr_bit;
            end
         end
         M_RST_LOW: begin
            // Reset low is kept well under the interrupt masking limit.
            if (s_reg.cnt == (CNT_W+1)'(fast ? RST_LOW_F_CYC : RST_LOW_CYC)) begin
               s_next.st  = M_RST_HIGH;
               s_next.low = 1'b0;
               s_next.cnt = '0;
            end
         end
         M_RST_HIGH: begin
            if (!bus.mst_in && s_reg.cnt > 1) begin
               s_next.pres = 1'b1;
            end
            if (s_reg.cnt == (CNT_W+1)'(fast ? RST_HIGH_F_CYC : RST_HIGH_CYC)) begin
               s_next.st   = M_IDLE;
               s_next.done = 1'b1;
            end
         end
         M_SLOT: begin
            if (s_reg.cnt == (CNT_W+1)'(s_reg.is_read ? (fast ? LOW1_F_CYC : LOW1_CYC)
                  : s_reg.bitv ? (fast ? LOW1_F_CYC : LOW1_CYC)
                  : (fast ? LOW0_F_CYC : LOW0_CYC))) begin
               s_next.low = 1'b0;
            end
            if (s_reg.is_read && s_reg.cnt == (CNT_W+1)'(fast ? READ_SMP_F_CYC
                                                              : READ_SMP_CYC)) begin
               s_next.rd = bus.mst_in;
            end
            if (s_reg.cnt == (CNT_W+1)'(fast ? SLOT_F_CYC : SLOT_CYC)) begin
               s_next.st  = M_REC;
               s_next.cnt = '0;
            end
         end
         M_REC: begin
            if (bus.mst_in && s_reg.cnt >= (CNT_W+1)'(fast ? REC_F_CYC : REC_CYC)) begin
               s_next.st   = M_IDLE;
               s_next.done = 1'b1;
            end
         end
         default: s_next.st = M_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end
endmodule : swire_master

// file: test/swire_checker.sv
module swire_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Device end of the line
   input wire logic dev_in,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   // Master end of the line
   input wire logic mst_in,
   input wire logic mst_out,
   input wire logic mst_oe_n,
   // Resolved wire
   input wire logic line
);
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Line timers
   // ---------------------------------------------------------------
   logic [15:0] hi_cnt;
   logic [15:0] low_cnt;
   logic [15:0] dev_low_cnt;
   logic [15:0] mst_low_cnt;

   function automatic logic [15:0] sat(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : sat

   // The high timer starts full, since an idle line counts as long recovered.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hi_cnt      <= 16'hFFFF;
         low_cnt     <= 16'h0000;
         dev_low_cnt <= 16'h0000;
         mst_low_cnt <= 16'h0000;
      end else begin
         hi_cnt      <= line ? sat(hi_cnt) : 16'h0000;
         low_cnt     <= line ? 16'h0000 : sat(low_cnt);
         dev_low_cnt <= dev_oe_n ? 16'h0000 : sat(dev_low_cnt);
         mst_low_cnt <= mst_oe_n ? 16'h0000 : sat(mst_low_cnt);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   dev_drive_low_a: assert property (dev_out == 1'b0)
      else $error("device drives a high level");
   mst_drive_low_a: assert property (mst_out == 1'b0)
      else $error("master drives a high level");
   presence_len_a: assert property ($rose(dev_oe_n) |-> dev_low_cnt inside {[1:480], [1200:4800]})
      else $error("device low pulse of wrong length");
   dev_low_bound_a: assert property (dev_low_cnt <= 4800)
      else $error("device holds line low too long");
   read_prompt_a: assert property ($fell(dev_oe_n) && !$past(line) |-> low_cnt <= 20)
      else $error("read zero not driven within 1 us");
   slot_start_a: assert property ($fell(line) |-> !mst_oe_n || hi_cnt inside {[40:120], [300:1200]})
      else $error("line fall not started by master");
   reset_bound_a: assert property (mst_low_cnt <= 19200)
      else $error("master low longer than 960 us");
   slot_recovery_a: assert property ($fell(mst_oe_n) |-> hi_cnt >= 19)
      else $error("master starts before recovery time");

   cover property ($fell(dev_oe_n) && $past(line));
   cover property ($fell(dev_oe_n) && !$past(line));
   cover property (mst_low_cnt == 9000);
endmodule : swire_checker

// file: test/tb_single_wire_crc_and_slot_timing.sv
module tb_single_wire_crc_and_slot_timing
   import swire_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk_sys = 0, reset = 1, fast = 0, cmd_reset = 0, cmd_write = 0, cmd_read = 0;
   logic wr_bit = 0, crc_clear = 0, crc_byte = 0, fast_speed_set = 0, tx_req = 0, tx_bit = 0;
   crc_op_t     crc_op = CRC_HOLD;
   logic [7:0]  crc_data = 8'h00;
   logic [15:0] crc_rx_word = 16'h0000;
   logic [4:0]  pad_start = 5'h00;
   logic [5:0]  pad_count = 6'h00;
   logic busy, done, rd_bit, presence, crc16_ok, fast_speed_flag, reset_seen;
   logic rx_valid, rx_bit, tx_done, crc_tx_allowed, seen_rst, seen_done;
   logic [7:0]  crc8, identity_crc, rx_sh;
   logic [15:0] crc_value, crc_tx_word;
   int miscompares = 0, checked = 0, cycles = 0;

   swire_if sw ();
   swire_device #(.IDENTITY(64'h5A00_1122_3344_5501)) u_swire_device (  // Arbitrary value.
      .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .bus(sw), .fast_speed_set(fast_speed_set),
      .tx_req(tx_req), .tx_bit(tx_bit), .crc_op(crc_op), .crc_data(crc_data),
      .pad_start(pad_start), .pad_count(pad_count), .fast_speed_flag(fast_speed_flag),
      .reset_seen(reset_seen), .rx_valid(rx_valid), .rx_bit(rx_bit), .tx_done(tx_done),
      .crc_value(crc_value), .crc_tx_word(crc_tx_word), .crc_tx_allowed(crc_tx_allowed),
      .identity_crc(identity_crc));
   swire_master u_swire_master (
      .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .bus(sw), .fast(fast),
      .cmd_reset(cmd_reset), .cmd_write(cmd_write), .cmd_read(cmd_read), .wr_bit(wr_bit),
      .busy(busy), .done(done), .rd_bit(rd_bit), .presence(presence), .crc_clear(crc_clear),
      .crc_byte(crc_byte), .crc_data(crc_data), .crc_rx_word(crc_rx_word),
      .crc16_ok(crc16_ok), .crc8(crc8));
   swire_checker u_checker (
      .clk_sys(clk_sys), .reset(reset), .dev_in(sw.dev_in), .dev_out(sw.dev_out),
      .dev_oe_n(sw.dev_oe_n), .mst_in(sw.mst_in), .mst_out(sw.mst_out),
      .mst_oe_n(sw.mst_oe_n), .line(sw.line));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Received bits arrive least significant first, so they shift in from the top.
   always @(negedge clk_sys) begin
      cycles++;
      if (reset_seen === 1'b1) seen_rst = 1'b1;
      if (tx_done === 1'b1) seen_done = 1'b1;
      if (rx_valid === 1'b1) rx_sh = {rx_bit, rx_sh[7:1]};
      if (cycles > 95000) begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Reflected shift register, one data byte per step, least significant bit first.
   function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d,
                                        input logic [15:0] p);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
      end
      return c;
   endfunction : step

   task automatic mcmd(input int kind, input logic b);
      int n;
      @(negedge clk_sys);
      wr_bit = b;
      cmd_reset = (kind == 0);
      cmd_write = (kind == 1);
      cmd_read = (kind == 2);
      @(negedge clk_sys);
      cmd_reset = 0;
      cmd_write = 0;
      cmd_read = 0;
      check(busy, 1'b1);
      n = 0;
      while (done !== 1'b1 && n < 30000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 30000) check(1'b0, 1'b1);
      check(busy, 1'b0);
   endtask : mcmd

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset(input logic f, input logic keep);
      fast = f;
      seen_rst = 1'b0;
      mcmd(0, 1'b0);
      check(presence, 1'b1);
      check(seen_rst, 1'b1);
      check(fast_speed_flag, keep);
   endtask : t_reset

   task automatic t_write(input logic [7:0] b, input logic f);
      fast = f;
      seen_done = 1'b0;
      for (int i = 0; i < 8; i++) mcmd(1, b[i]);
      check(rx_sh, b);
      check(seen_done, 1'b0);
   endtask : t_write

   task automatic t_read(input logic b, input logic f);
      fast = f;
      tx_req = 1'b1;
      tx_bit = b;
      seen_done = 1'b0;
      mcmd(2, 1'b0);
      tx_req = 1'b0;
      check(rd_bit, b);
      check(seen_done, 1'b1);
   endtask : t_read

   task automatic t_crc(input logic [7:0] q[$], input logic [4:0] st, input logic [5:0] cnt,
                        input logic ok);
      logic [15:0] e;
      logic [15:0] e8;
      e = 16'h0000;
      e8 = 16'h0000;
      @(negedge clk_sys);
      crc_op = CRC_CLEAR;
      crc_clear = 1'b1;
      foreach (q[i]) begin
         @(negedge clk_sys);
         crc_op = CRC_BYTE;
         crc_clear = 1'b0;
         crc_byte = 1'b1;
         crc_data = q[i];
         e = step(e, q[i], 16'hA001);
         e8 = step(e8, q[i], 16'h008C);
      end
      @(negedge clk_sys);
      crc_op = CRC_HOLD;
      crc_byte = 1'b0;
      pad_start = st;
      pad_count = cnt;
      crc_rx_word = ok ? ~e : ~e ^ 16'h0001;
      @(negedge clk_sys);
      check(crc_value, e);
      check(crc_tx_word, ~e);
      check(crc16_ok, ok);
      check(crc8, e8);
      check(crc_tx_allowed, (int'(st) + int'(cnt)) >= 32);
   endtask : t_crc

   initial begin
      repeat (12) @(negedge clk_sys);
      reset = 0;
      check(identity_crc, 8'h5A);
      t_reset(1'b0, 1'b0);
      t_write(8'hA5, 1'b0);
      t_read(1'b0, 1'b0);
      t_read(1'b1, 1'b0);
      @(negedge clk_sys);
      fast_speed_set = 1'b1;
      @(negedge clk_sys);
      fast_speed_set = 1'b0;
      t_reset(1'b1, 1'b1);
      t_write(8'h3C, 1'b1);
      t_read(1'b0, 1'b1);
      t_read(1'b1, 1'b1);
      t_reset(1'b0, 1'b0);
      t_crc('{8'h0F, 8'h1C, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44}, 5'h1C, 6'h04, 1'b1);
      t_crc('{8'h0F, 8'h05, 8'h00, 8'hC3, 8'h7E}, 5'h05, 6'h02, 1'b0);
      t_crc('{8'h0F, 8'h1F, 8'h00, 8'hE7}, 5'h1F, 6'h3F, 1'b1);
      t_crc('{8'hA5, 8'h20, 8'h00, 8'h9A, 8'h01, 8'h00, 8'h00, 8'h00}, 5'h00, 6'h20, 1'b1);
      t_crc('{8'h9A, 8'h02, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF}, 5'h00, 6'h1F, 1'b0);
      t_crc('{8'h01, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'h00}, 5'h00, 6'h00, 1'b1);
      report_and_stop();
   end

   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
endmodule : tb_single_wire_crc_and_slot_timing
